// file: src/rscg_top.sv
// Serial shift register that recirculates its pattern and can pace a serial clock.
//
// How it works
// [R1] Output modes rotate bit 7 back into bit 0, keeping the pattern intact.
// [R2] A read strobe starts a shift sequence without loading new data.
// [R3] Continuous output mode rotates the 8-bit pattern out without ever stopping.
// [R4] Continuous mode advances one bit each time the interval timer expires.
// [R5] Timer-paced bit period is programmable up to 256 system clock cycles.
// [R6] Serial data out changes only after a falling edge of the serial clock.
// [R7] Incoming serial data is captured on the rising edge of the serial clock.
// [R8] A sticky done flag rises when a shift sequence completes.
// [R9] Internal serial clock is low then high within each bit period.
`timescale 1ns/10ps
module rscg_top
  import rscg_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire rscg_mode_e mode_i,
  input  wire logic [7:0] period_i,
  input  wire logic       load_valid_i,
  input  wire logic [7:0] load_data_i,
  input  wire logic       read_strobe_i,
  input  wire logic       flag_clear_i,
  input  wire logic       link_clk_i,
  input  wire logic       sdata_i,
  output logic            sclk_o,
  output logic            sclk_oe_o,
  output logic            sdata_o,
  output logic            sdata_oe_o,
  output logic [7:0]      data_o,
  output logic            done_flag_o,
  output logic            busy_o
);

  // System clock domain state.
  rscg_state_e state;
  rscg_state_e next_state;
  logic [7:0]  cnt;
  logic [7:0]  next_cnt;
  logic [2:0]  bits;
  logic [2:0]  next_bits;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic        next_sclk;
  logic        next_sclk_oe;
  logic        next_sdo;
  logic        next_sdo_oe;
  logic        next_flag;
  logic        start_tgl;
  logic        next_start_tgl;
  logic        done_seen;
  logic        next_done_seen;
  logic        ext_dir_out;
  logic        next_ext_dir_out;
  logic        sdi_meta;
  logic        sdi_sync;
  logic        done_meta;
  logic        done_sync;
  logic        lout_meta;
  logic        lout_sync;

  // Link clock domain state.
  logic        lrst_meta;
  logic        lrst_n;
  logic        lstart_meta;
  logic        lstart_sync;
  logic        lstart_seen;
  logic        next_lstart_seen;
  logic        ldir_out;
  logic        next_ldir_out;
  logic        lbusy;
  logic        next_lbusy;
  logic [2:0]  lbits;
  logic [2:0]  next_lbits;
  logic [7:0]  lshreg;
  logic [7:0]  next_lshreg;
  logic        ldone_tgl;
  logic        next_ldone_tgl;
  logic        lout;

  logic [7:0]  period_eff;
  logic [7:0]  half;
  logic        start_req;
  logic        mode_out;
  logic        mode_in;
  logic        mode_ext;
  logic        done_set;

  assign data_o = shreg;

  // A zero period would leave no room for a rising edge, so it acts as one.
  assign period_eff = (period_i == 8'h00) ? RSCG_MIN_PERIOD : period_i; // [R5]
  assign half       = {1'b0, period_eff[7:1]};
  assign start_req  = load_valid_i | read_strobe_i; // [R2]
  assign mode_out   = (mode_i == RSCG_OUT_INT) | (mode_i == RSCG_OUT_CONT)
                      | (mode_i == RSCG_OUT_EXT);
  assign mode_in    = (mode_i == RSCG_IN_INT) | (mode_i == RSCG_IN_EXT);
  assign mode_ext   = (mode_i == RSCG_IN_EXT) | (mode_i == RSCG_OUT_EXT);

  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_bits        = bits;
    next_shreg       = shreg;
    next_sclk        = sclk_o;
    next_sdo         = sdata_o;
    next_start_tgl   = start_tgl;
    next_done_seen   = done_seen;
    next_ext_dir_out = ext_dir_out;
    next_sclk_oe     = (mode_i != RSCG_OFF) & ~mode_ext;
    next_sdo_oe      = mode_out;
    done_set         = 1'b0;
    case (state)
      RSCG_ST_IDLE: begin
        next_sclk = RSCG_SCLK_IDLE;
        if (load_valid_i) begin
          next_shreg = load_data_i;
        end
        if (start_req && (mode_i != RSCG_OFF)) begin
          if (mode_ext) begin
            next_start_tgl   = ~start_tgl;
            next_ext_dir_out = mode_out;
            next_state       = RSCG_ST_EXT;
          end else begin
            next_state = RSCG_ST_RUN;
            next_cnt   = period_eff;
            next_bits  = RSCG_BITS_RST;
            next_sclk  = 1'b0; // [R9]
            if (mode_out) begin
              next_sdo   = next_shreg[7]; // [R6]
              next_shreg = {next_shreg[6:0], next_shreg[7]}; // [R1]
            end
          end
        end
      end
      RSCG_ST_RUN: begin
        if (mode_i == RSCG_OFF || mode_ext) begin
          next_state = RSCG_ST_IDLE;
          next_sclk  = RSCG_SCLK_IDLE;
        end else if (cnt == 8'h00) begin
          if (bits == RSCG_LAST_BIT && mode_i != RSCG_OUT_CONT) begin
            next_state = RSCG_ST_IDLE;
            next_sclk  = RSCG_SCLK_IDLE;
            done_set   = 1'b1; // [R8]
          end else begin
            // Continuous mode wraps the bit count and keeps going. [R3]
            next_bits = bits + 3'h1;
            next_cnt  = period_eff; // [R4]
            next_sclk = 1'b0; // [R9]
            if (mode_out) begin
              next_sdo   = shreg[7]; // [R6]
              next_shreg = {shreg[6:0], shreg[7]}; // [R1]
            end
          end
        end else begin
          next_cnt = cnt - 8'h01;
          if (next_cnt == half) begin
            next_sclk = 1'b1; // [R9]
            if (mode_in) begin
              next_shreg = {shreg[6:0], sdi_sync}; // [R7]
            end
          end
        end
      end
      RSCG_ST_EXT: begin
        // The serial data pin follows the link side, which changes it on falls.
        next_sdo = lout_sync; // [R6]
        if (done_sync != done_seen) begin
          // The link word stays still until the next start, so it is safe to copy.
          next_done_seen = done_sync;
          next_shreg     = lshreg;
          next_state     = RSCG_ST_IDLE;
          done_set       = 1'b1; // [R8]
        end
      end
      default: begin
        next_state = RSCG_ST_IDLE;
      end
    endcase
    // A completion in the same cycle as a clear keeps the flag set.
    if (done_set) begin
      next_flag = 1'b1; // [R8]
    end else if (flag_clear_i || (start_req && state == RSCG_ST_IDLE)) begin
      next_flag = 1'b0;
    end else begin
      next_flag = done_flag_o;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    sdi_meta  <= sdata_i;
    sdi_sync  <= sdi_meta;
    done_meta <= ldone_tgl;
    done_sync <= done_meta;
    lout_meta <= lout;
    lout_sync <= lout_meta;
    if (!resetn_i) begin
      state       <= RSCG_ST_IDLE;
      cnt         <= RSCG_CNT_RST;
      bits        <= RSCG_BITS_RST;
      shreg       <= RSCG_SHREG_RST;
      sclk_o      <= RSCG_SCLK_IDLE;
      sclk_oe_o   <= 1'b0;
      sdata_o     <= RSCG_SDO_RST;
      sdata_oe_o  <= 1'b0;
      done_flag_o <= 1'b0;
      busy_o      <= 1'b0;
      start_tgl   <= 1'b0;
      done_seen   <= 1'b0;
      ext_dir_out <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      bits        <= next_bits;
      shreg       <= next_shreg;
      sclk_o      <= next_sclk;
      sclk_oe_o   <= next_sclk_oe;
      sdata_o     <= next_sdo;
      sdata_oe_o  <= next_sdo_oe;
      done_flag_o <= next_flag;
      busy_o      <= (next_state != RSCG_ST_IDLE);
      start_tgl   <= next_start_tgl;
      done_seen   <= next_done_seen;
      ext_dir_out <= next_ext_dir_out;
    end
  end

  // The external clock may idle between frames; the start toggle needs two of
  // its edges to arrive and a third to load, so the far end must give three lead-in edges per frame.
  always_comb begin
    next_lstart_seen = lstart_seen;
    next_ldir_out    = ldir_out;
    next_lbusy       = lbusy;
    next_lbits       = lbits;
    next_lshreg      = lshreg;
    next_ldone_tgl   = ldone_tgl;
    if (lstart_sync != lstart_seen) begin
      next_lstart_seen = lstart_sync;
      next_ldir_out    = ext_dir_out;
      next_lshreg      = shreg;
      next_lbits       = RSCG_BITS_RST;
      next_lbusy       = 1'b1;
    end else if (lbusy) begin
      if (ldir_out) begin
        next_lshreg = {lshreg[6:0], lshreg[7]}; // [R1]
      end else begin
        next_lshreg = {lshreg[6:0], sdata_i}; // [R7]
      end
      next_lbits = lbits + 3'h1;
      if (lbits == RSCG_LAST_BIT) begin
        next_lbusy     = 1'b0;
        next_ldone_tgl = ~ldone_tgl;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    lrst_meta   <= resetn_i;
    lrst_n      <= lrst_meta;
    lstart_meta <= start_tgl;
    lstart_sync <= lstart_meta;
    if (!lrst_n) begin
      lstart_seen <= 1'b0;
      ldir_out    <= 1'b0;
      lbusy       <= 1'b0;
      lbits       <= RSCG_BITS_RST;
      lshreg      <= RSCG_SHREG_RST;
      ldone_tgl   <= 1'b0;
    end else begin
      lstart_seen <= next_lstart_seen;
      ldir_out    <= next_ldir_out;
      lbusy       <= next_lbusy;
      lbits       <= next_lbits;
      lshreg      <= next_lshreg;
      ldone_tgl   <= next_ldone_tgl;
    end
  end

  always_ff @(negedge link_clk_i) begin
    if (!lrst_n) begin
      lout <= RSCG_SDO_RST;
    end else begin
      lout <= lshreg[7]; // [R6]
    end
  end

endmodule

// file: src/rscg_pkg.sv
// Shared constants and types for the recirculating shift and clock generator.
package rscg_pkg;

  localparam int unsigned RSCG_BITS       = 8;
  localparam logic [7:0]  RSCG_SHREG_RST  = 8'h00;
  localparam logic [7:0]  RSCG_CNT_RST    = 8'h00;
  localparam logic [7:0]  RSCG_MIN_PERIOD = 8'h01;
  localparam logic [2:0]  RSCG_BITS_RST   = 3'h0;
  localparam logic [2:0]  RSCG_LAST_BIT   = 3'h7;
  localparam logic        RSCG_SCLK_IDLE  = 1'b1;
  localparam logic        RSCG_SDO_RST    = 1'b0;

  typedef enum logic [2:0] {
    RSCG_OFF,
    RSCG_IN_INT,
    RSCG_OUT_INT,
    RSCG_OUT_CONT,
    RSCG_IN_EXT,
    RSCG_OUT_EXT
  } rscg_mode_e;

  typedef enum logic [1:0] {
    RSCG_ST_IDLE,
    RSCG_ST_RUN,
    RSCG_ST_EXT
  } rscg_state_e;

endpackage

// file: test/rscg_properties.sv
// Concurrent checks on the ports of the shift and clock generator.
`timescale 1ns/10ps
module rscg_properties
  import rscg_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire rscg_mode_e mode_i,
  input wire logic [7:0] period_i,
  input wire logic       load_valid_i,
  input wire logic       read_strobe_i,
  input wire logic       sclk_o,
  input wire logic       sclk_oe_o,
  input wire logic       sdata_o,
  input wire logic       done_flag_o,
  input wire logic       busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic       armed;
  logic [8:0] since;
  logic [8:0] eff;
  assign eff = (period_i == 8'h00) ? 9'h001 : {1'b0, period_i};
  // Only falls seen while running arm the check, so a stale count never judges a bit.
  always_ff @(posedge sys_clk_i) begin
    armed <= resetn_i && busy_o && ($fell(sclk_o) || armed);
    since <= $fell(sclk_o) ? 9'h001 : since + 9'h001;
  end
  sequence s_start;
    (load_valid_i || read_strobe_i) && !busy_o && mode_i inside {RSCG_IN_INT, RSCG_OUT_INT};
  endsequence
  sequence s_first_bit;
    !sclk_o && busy_o;
  endsequence
  start_fall_a: assert property (s_start |=> s_first_bit)
    else $error("no clock fall at start");
  read_start_a: assert property (read_strobe_i && !busy_o && mode_i == RSCG_OUT_INT
    |=> busy_o [*2]) else $error("read did not start");
  // With an external clock the data follows the link side, which this domain cannot see.
  sdo_fall_a: assert property (busy_o && $past(busy_o) && sclk_oe_o && $changed(sdata_o)
    |-> $fell(sclk_o)) else $error("data moved off a fall");
  done_rise_a: assert property ($fell(busy_o) && $past(mode_i, 2) == mode_i
    && mode_i inside {RSCG_IN_INT, RSCG_OUT_INT} |-> $rose(done_flag_o))
    else $error("no done flag");
  cont_run_a: assert property (busy_o && mode_i == RSCG_OUT_CONT && $past(mode_i) == mode_i
    |=> busy_o && !done_flag_o) else $error("continuous run stopped");
  bit_period_a: assert property (armed && busy_o && $fell(sclk_o) |-> since == eff + 9'h001)
    else $error("bit length wrong");
  low_half_a: assert property (busy_o && $rose(sclk_o) |-> since == eff - (eff >> 1))
    else $error("low phase wrong");
  idle_high_a: assert property (!busy_o && !$past(busy_o) && sclk_oe_o |-> sclk_o)
    else $error("clock not idle high");
endmodule
bind rscg_top rscg_properties u_props (
  .sys_clk_i     (sys_clk_i),
  .resetn_i      (resetn_i),
  .mode_i        (mode_i),
  .period_i      (period_i),
  .load_valid_i  (load_valid_i),
  .read_strobe_i (read_strobe_i),
  .sclk_o        (sclk_o),
  .sclk_oe_o     (sclk_oe_o),
  .sdata_o       (sdata_o),
  .done_flag_o   (done_flag_o),
  .busy_o        (busy_o)
);

// file: test/rscg_peer.sv
// Model of the peripheral shift register beyond the serial pins.
`timescale 1ns/10ps
module rscg_peer (
  input  wire logic       sck_i,
  input  wire logic       sdo_i,
  input  wire logic       frame_i,
  input  wire logic       load_i,
  input  wire logic [7:0] tx_i,
  output logic            link_clk_o,
  output logic            sdi_o,
  output logic [7:0]      rx_o
);
  logic [7:0] sh = 8'h00;
  initial begin
    link_clk_o = 1'b1;
    sdi_o = 1'b0;
    rx_o = 8'h00;
  end
  // The clock stands high between frames; lead-in periods cover the crossing delay.
  always @(posedge frame_i) begin
    repeat (14) begin
      #24 link_clk_o = 1'b0;
      #24 link_clk_o = 1'b1;
    end
  end
  always @(posedge load_i) sh = tx_i;
  always @(negedge sck_i) begin
    sdi_o <= sh[7];
    sh <= {sh[6:0], sh[7]};
  end
  always @(posedge sck_i) rx_o <= {rx_o[6:0], sdo_i};
endmodule

// file: test/tb.sv
// Self-checking bench for the recirculating shift and clock generator.
`timescale 1ns/10ps
module tb;
  import rscg_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  rscg_mode_e mode_i = RSCG_OFF;
  logic [7:0] period_i = 8'h00;
  logic       load_valid_i = 1'b0;
  logic [7:0] load_data_i = 8'h00;
  logic       read_strobe_i = 1'b0;
  logic       flag_clear_i = 1'b0;
  logic       frame = 1'b0;
  logic       pload = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic       link_clk_i, sdata_i, sclk_o, sclk_oe_o, sdata_o, sdata_oe_o, done_flag_o, busy_o;
  logic [7:0] data_o, rx;
  wire        sck = sclk_oe_o ? sclk_o : link_clk_i;
  int         fail_count = 0;
  int         total_checks = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  rscg_top DUT (
    .sys_clk_i     (sys_clk_i),
    .resetn_i      (resetn_i),
    .mode_i        (mode_i),
    .period_i      (period_i),
    .load_valid_i  (load_valid_i),
    .load_data_i   (load_data_i),
    .read_strobe_i (read_strobe_i),
    .flag_clear_i  (flag_clear_i),
    .link_clk_i    (link_clk_i),
    .sdata_i       (sdata_i),
    .sclk_o        (sclk_o),
    .sclk_oe_o     (sclk_oe_o),
    .sdata_o       (sdata_o),
    .sdata_oe_o    (sdata_oe_o),
    .data_o        (data_o),
    .done_flag_o   (done_flag_o),
    .busy_o        (busy_o)
  );
  rscg_peer u_peer (.sck_i(sck), .sdo_i(sdata_o), .frame_i(frame), .load_i(pload),
    .tx_i(ptx), .link_clk_o(link_clk_i), .sdi_o(sdata_i), .rx_o(rx));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic run(input rscg_mode_e m, input logic [7:0] per, input logic ld,
                     input logic [7:0] d);
    @(negedge sys_clk_i);
    mode_i = m;
    period_i = per;
    load_data_i = d;
    load_valid_i = ld;
    read_strobe_i = !ld;
    @(negedge sys_clk_i);
    load_valid_i = 1'b0;
    read_strobe_i = 1'b0;
  endtask
  task automatic wait_idle(input int lim);
    int i;
    for (i = 0; i < lim && busy_o !== 1'b0; i++) @(negedge sys_clk_i);
    if (i == lim) begin
      chk("busy_o", 8'h00, {7'h00, busy_o});
      conclude();
    end
  endtask
  task automatic peer_word(input logic [7:0] w);
    ptx = w;
    pload = 1'b1;
    #1 pload = 1'b0;
  endtask
  task automatic test_out_int();
    run(RSCG_OUT_INT, 8'h01, 1'b1, 8'ha5);
    wait_idle(100);
    chk("data_o", 8'ha5, data_o);
    chk("rx", 8'ha5, rx);
    chk("done_flag_o", 8'h01, {7'h00, done_flag_o});
    chk("sclk_oe_o", 8'h01, {7'h00, sclk_oe_o});
    chk("sdata_oe_o", 8'h01, {7'h00, sdata_oe_o});
    flag_clear_i = 1'b1;
    @(negedge sys_clk_i);
    flag_clear_i = 1'b0;
    chk("done_flag_o", 8'h00, {7'h00, done_flag_o});
    $display("test out_int done");
  endtask
  task automatic test_read();
    run(RSCG_OUT_INT, 8'hff, 1'b0, 8'h00);
    // A load while busy must be ignored, so the old pattern comes back.
    load_valid_i = 1'b1;
    @(negedge sys_clk_i);
    load_valid_i = 1'b0;
    wait_idle(3000);
    chk("data_o", 8'ha5, data_o);
    chk("rx", 8'ha5, rx);
    $display("test read done");
  endtask
  task automatic test_cont();
    run(RSCG_OUT_CONT, 8'h03, 1'b1, 8'h81);
    repeat (289) @(negedge sys_clk_i);
    chk("rx", 8'h81, rx);
    chk("busy_o", 8'h01, {7'h00, busy_o});
    mode_i = RSCG_OFF;
    wait_idle(10);
    $display("test cont done");
  endtask
  task automatic test_in_int();
    peer_word(8'h3c);
    run(RSCG_IN_INT, 8'h07, 1'b0, 8'h00);
    wait_idle(200);
    chk("data_o", 8'h3c, data_o);
    chk("sdata_oe_o", 8'h00, {7'h00, sdata_oe_o});
    $display("test in_int done");
  endtask
  task automatic test_ext();
    peer_word(8'hff);
    run(RSCG_IN_EXT, 8'h00, 1'b0, 8'h00);
    frame = 1'b1;
    wait_idle(400);
    frame = 1'b0;
    chk("data_o", 8'hff, data_o);
    chk("sclk_oe_o", 8'h00, {7'h00, sclk_oe_o});
    repeat (60) @(negedge sys_clk_i);
    run(RSCG_OUT_EXT, 8'h00, 1'b1, 8'h5a);
    frame = 1'b1;
    wait_idle(400);
    frame = 1'b0;
    chk("data_o", 8'h5a, data_o);
    chk("sdata_oe_o", 8'h01, {7'h00, sdata_oe_o});
    $display("test ext done");
  endtask
  initial begin
    #1 frame = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    frame = 1'b0;
    repeat (150) @(negedge sys_clk_i);
    test_out_int();
    test_read();
    test_cont();
    test_in_int();
    test_ext();
    conclude();
  end
endmodule
